// >>> rtl/dcc_pkg.sv
// Shared constants and types of the 10-bit converter code control
package dcc_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int          ADR_W      = 8;
   localparam int          CODE_W     = 10;
   localparam int          PIN_N      = 2;

   // ****************************************************************
   // Register offsets (byte addresses, one word each)
   // ****************************************************************
   localparam logic [7:0]  OFF_CTRL   = 8'h00;
   localparam logic [7:0]  OFF_HIGH   = 8'h04;
   localparam logic [7:0]  OFF_LOW    = 8'h08;
   localparam logic [7:0]  OFF_LOAD   = 8'h0c;
   localparam logic [7:0]  OFF_STATUS = 8'h10;
   localparam logic [7:0]  OFF_ACTIVE = 8'h14;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int          LOAD_BIT   = 0;
   localparam int          ST_LOAD    = 0;
   localparam int          ST_ON      = 1;
   localparam int          ST_RSVD    = 2;
   localparam int          LJ_LOW_MSB = 7;
   localparam int          LJ_LOW_LSB = 6;
   localparam int          RJ_HIGH_W  = 2;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [7:0]  BYTE_RST   = 8'h00;
   localparam logic [9:0]  CODE_RST   = 10'h000;

   // ****************************************************************
   // Source selects and carriers
   // ****************************************************************
   typedef enum logic [1:0] {
      POS_SUPPLY  = 2'h0,
      POS_EXT_REF = 2'h1,
      POS_FIXED   = 2'h2,
      POS_RSVD    = 2'h3
   } dcc_pos_src_e;

   typedef enum logic [1:0] {
      NEG_AGND    = 2'h0,
      NEG_PIN0    = 2'h1,
      NEG_PIN1    = 2'h2,
      NEG_RSVD    = 2'h3
   } dcc_neg_src_e;

   typedef struct packed {
      logic         en;
      logic         justify_format;
      logic         pin1_output_enable;
      logic         pin2_output_enable;
      dcc_pos_src_e positive_source_select;
      dcc_neg_src_e negative_source_select;
   } dcc_ctrl_s;

   typedef struct packed {
      logic [9:0]   level;
      logic         on;
      dcc_pos_src_e pos_src;
      dcc_neg_src_e neg_src;
   } dcc_level_s;

endpackage

// >>> rtl/dcc_pin.sv
// Digital pad override for one converter output pin
module dcc_pin (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Analog selection
   input  wire logic analog_sel_i,
   // Port logic side
   input  wire logic gpio_out_i,
   input  wire logic gpio_oe_i,
   output logic      gpio_in_o,
   // Pad side
   input  wire logic pad_in_i,
   output logic      pad_out_o,
   output logic      pad_oe_o,
   output logic      pad_ibuf_en_o
);

   // ****************************************************************
   // Driver and input detector override
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pad_out_o     <= 1'b0;
         pad_oe_o      <= 1'b0;
         pad_ibuf_en_o <= 1'b1;
         gpio_in_o     <= 1'b0;
      end else begin
         // Analog use kills the driver and the threshold detector
         pad_out_o     <= gpio_out_i & ~analog_sel_i;
         pad_oe_o      <= gpio_oe_i & ~analog_sel_i;
         pad_ibuf_en_o <= ~analog_sel_i;
         gpio_in_o     <= pad_in_i & ~analog_sel_i;
      end
   end

endmodule

// >>> rtl/dcc_top.sv
// Wishbone-controlled code and pin logic of a 10-bit reference converter
module dcc_top #(
   parameter bit HAS_NEG1 = 1'b0
) (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // Wishbone slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   // Internal consumers
   output dcc_pkg::dcc_level_s       level_o,
   // Analog pin switches
   output logic      [1:0]           analog_out_pin_o,
   // Port logic side of the two pins
   input  wire logic [1:0]           gpio_out_i,
   input  wire logic [1:0]           gpio_oe_i,
   output logic      [1:0]           gpio_in_o,
   // Pads
   input  wire logic [1:0]           pad_in_i,
   output logic      [1:0]           pad_out_o,
   output logic      [1:0]           pad_oe_o,
   output logic      [1:0]           pad_ibuf_en_o
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   dcc_pkg::dcc_ctrl_s ctrl_q;
   logic [7:0]         high_q;
   logic [7:0]         low_q;
   logic               load_q;
   logic [9:0]         active_q;
   logic               ack_q;
   logic [31:0]        dat_q;
   logic               req_w;
   logic               acc_w;
   logic               wr_w;
   logic [9:0]         code_w;
   logic               rsvd_w;
   logic [1:0]         pin_sel_w;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic hit(input logic [7:0] adr,
                                input logic [7:0] off);
      hit = (adr == off);
   endfunction

   // Unused bits of a byte depend on the format in force
   function automatic logic [7:0] mask_byte(input logic       is_high,
                                            input logic       fmt,
                                            input logic [7:0] val);
      logic [7:0] m;
      m = 8'hff;
      if (is_high && !fmt)
         m = 8'h03;
      if (!is_high && fmt)
         m = 8'hc0;
      mask_byte = val & m;
   endfunction

   // ****************************************************************
   // Bus handshake
   // ****************************************************************
   assign req_w = wb_cyc_i & wb_stb_i;
   // Writes land on the edge where the master sees ack
   assign acc_w = req_w & ack_q;
   assign wr_w  = acc_w & wb_we_i & wb_sel_i[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req_w & ~ack_q;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // ****************************************************************
   // Control register
   // ****************************************************************
   // Only a write or reset moves it; sleep and wake have no path here
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= dcc_pkg::dcc_ctrl_s'(dcc_pkg::CTRL_RST);
      end else if (wr_w && hit(wb_adr_i, dcc_pkg::OFF_CTRL)) begin
         ctrl_q <= dcc_pkg::dcc_ctrl_s'(wb_dat_i[7:0]);
      end
   end

   // ****************************************************************
   // Code bytes
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         high_q <= dcc_pkg::BYTE_RST;
      end else if (wr_w && hit(wb_adr_i, dcc_pkg::OFF_HIGH)) begin
         high_q <= mask_byte(1'b1, ctrl_q.justify_format,
                             wb_dat_i[7:0]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_q <= dcc_pkg::BYTE_RST;
      end else if (wr_w && hit(wb_adr_i, dcc_pkg::OFF_LOW)) begin
         low_q <= mask_byte(1'b0, ctrl_q.justify_format,
                            wb_dat_i[7:0]);
      end
   end

   // Assemble the ten-bit word from the two bytes
   always_comb begin
      if (ctrl_q.justify_format) begin
         code_w = {high_q,
                   low_q[dcc_pkg::LJ_LOW_MSB:dcc_pkg::LJ_LOW_LSB]};
      end else begin
         code_w = {high_q[dcc_pkg::RJ_HIGH_W-1:0], low_q};
      end
   end

   // ****************************************************************
   // Load strobe and active buffer
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         load_q <= 1'b0;
      end else if (wr_w && hit(wb_adr_i, dcc_pkg::OFF_LOAD) &&
                   wb_dat_i[dcc_pkg::LOAD_BIT]) begin
         load_q <= 1'b1;
      end else begin
         // A zero write leaves it low; a set one drops after transfer
         load_q <= 1'b0;
      end
   end

   // Ten bits move on one edge, so no glitch through a half code
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_q <= dcc_pkg::CODE_RST;
      end else if (load_q) begin
         active_q <= code_w;
      end
   end

   // ****************************************************************
   // Source select check
   // ****************************************************************
   // Reserved codes are passed through; only flagged for software
   always_comb begin
      rsvd_w = (ctrl_q.positive_source_select == dcc_pkg::POS_RSVD) ||
               (ctrl_q.negative_source_select == dcc_pkg::NEG_RSVD);
      if (ctrl_q.negative_source_select == dcc_pkg::NEG_PIN1 && !HAS_NEG1)
         rsvd_w = 1'b1;
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0000_0000;
      end else if (req_w && !ack_q) begin
         dat_q <= 32'h0000_0000;
         case (wb_adr_i)
            dcc_pkg::OFF_CTRL:
               dat_q[7:0] <= ctrl_q;
            dcc_pkg::OFF_HIGH:
               dat_q[7:0] <= mask_byte(1'b1, ctrl_q.justify_format, high_q);
            dcc_pkg::OFF_LOW:
               dat_q[7:0] <= mask_byte(1'b0, ctrl_q.justify_format,
                                       low_q);
            dcc_pkg::OFF_LOAD:
               dat_q[dcc_pkg::LOAD_BIT] <= load_q;
            dcc_pkg::OFF_STATUS: begin
               dat_q[dcc_pkg::ST_LOAD] <= load_q;
               dat_q[dcc_pkg::ST_ON]   <= ctrl_q.en;
               dat_q[dcc_pkg::ST_RSVD] <= rsvd_w;
            end
            dcc_pkg::OFF_ACTIVE:
               dat_q[9:0] <= active_q;
            default:
               dat_q <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************************************
   // Converter outputs
   // ****************************************************************
   // Consumers see the level whatever the pin enables say
   assign level_o.level = active_q;
   assign level_o.on    = ctrl_q.en;
   assign level_o.pos_src = ctrl_q.positive_source_select;
   assign level_o.neg_src = ctrl_q.negative_source_select;

   assign pin_sel_w[0]     = ctrl_q.pin1_output_enable;
   assign pin_sel_w[1]     = ctrl_q.pin2_output_enable;
   assign analog_out_pin_o = pin_sel_w;

   // ****************************************************************
   // Pin overrides
   // ****************************************************************
   for (genvar g = 0; g < dcc_pkg::PIN_N; g++) begin : g_pin
      dcc_pin u_pin (
         .clk_i         (clk_i),
         .rst_i         (rst_i),
         .analog_sel_i  (pin_sel_w[g]),
         .gpio_out_i    (gpio_out_i[g]),
         .gpio_oe_i     (gpio_oe_i[g]),
         .gpio_in_o     (gpio_in_o[g]),
         .pad_in_i      (pad_in_i[g]),
         .pad_out_o     (pad_out_o[g]),
         .pad_oe_o      (pad_oe_o[g]),
         .pad_ibuf_en_o (pad_ibuf_en_o[g])
      );
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_en_follows_write: assert property (
      wr_w && hit(wb_adr_i, dcc_pkg::OFF_CTRL)
      |=> level_o.on == $past(wb_dat_i[7]))
      else $error("enable does not follow control write");

   a_left_format: assert property (
      load_q && ctrl_q.justify_format
      |=> active_q == {$past(high_q), $past(low_q[7:6])})
      else $error("left format load took wrong bits");

   a_right_format: assert property (
      load_q && !ctrl_q.justify_format
      |=> active_q == {$past(high_q[1:0]), $past(low_q)})
      else $error("right format load took wrong bits");

   a_code_holds: assert property (
      !load_q |=> $stable(active_q))
      else $error("active code moved without load");

   a_load_commit: assert property (
      wr_w && hit(wb_adr_i, dcc_pkg::OFF_LOAD) && wb_dat_i[0]
      |=> load_q ##1 (active_q == $past(code_w)) && !load_q)
      else $error("load strobe did not commit code");

   a_pin1_isolate: assert property (
      ctrl_q.pin1_output_enable && $past(ctrl_q.pin1_output_enable)
      |-> !pad_oe_o[0] && !pad_ibuf_en_o[0] && !gpio_in_o[0])
      else $error("pin one digital path not cut");

   a_pin2_read_zero: assert property (
      ctrl_q.pin2_output_enable |=> !gpio_in_o[1] && !pad_oe_o[1])
      else $error("pin two digital read not zero");

   a_ctrl_steady: assert property (
      !(wr_w && hit(wb_adr_i, dcc_pkg::OFF_CTRL)) |=> $stable(ctrl_q))
      else $error("control changed without a write");

   a_strobe_self_clear: assert property (
      load_q |=> !load_q)
      else $error("load strobe stuck high");

   a_zero_write_idle: assert property (
      wr_w && hit(wb_adr_i, dcc_pkg::OFF_LOAD) && !wb_dat_i[0] && !load_q
      |=> !load_q ##1 $stable(active_q))
      else $error("zero write to strobe had effect");

   a_reset_clear: assert property (
      disable iff (1'b0)
      $past(rst_i) |-> ctrl_q == dcc_pkg::CTRL_RST &&
                      active_q == dcc_pkg::CODE_RST &&
                      analog_out_pin_o == 2'h0)
      else $error("reset left converter state");

   a_ack_one_cycle: assert property (
      ack_q |=> !ack_q)
      else $error("ack held for two cycles");

   c_load_commit: cover property (load_q ##1 active_q != 10'h000);
   c_left_load:   cover property (load_q && ctrl_q.justify_format);
   c_pin1_analog: cover property (ctrl_q.pin1_output_enable && ctrl_q.en);
   c_rsvd_select: cover property (rsvd_w);

endmodule

// >>> testbench/test_dcc_top.sv
// Self-checking bench for the converter code control block
module test_dcc_top;
   timeunit 1ns;
   timeprecision 1ns;

   // ************************************************************
   // Signals
   // ************************************************************
   localparam bit        NEG1 = 1'b0;
   logic                 clk_i;
   logic                 rst_i;
   logic                 wb_cyc_i;
   logic                 wb_stb_i;
   logic                 wb_we_i;
   logic [7:0]           wb_adr_i;
   logic [3:0]           wb_sel_i;
   logic [31:0]          wb_dat_i;
   logic [31:0]          wb_dat_o;
   logic                 wb_ack_o;
   dcc_pkg::dcc_level_s  level_o;
   logic [1:0]           analog_out_pin_o;
   logic [1:0]           gpio_out_i;
   logic [1:0]           gpio_oe_i;
   logic [1:0]           gpio_in_o;
   logic [1:0]           pad_in_i;
   logic [1:0]           pad_out_o;
   logic [1:0]           pad_oe_o;
   logic [1:0]           pad_ibuf_en_o;
   int                   miscompares = 0;
   int                   n_checks = 0;
   int                   cycles = 0;
   logic [31:0]          q;
   logic [3:0]           sel_v;

   dcc_top #(.HAS_NEG1(NEG1)) u_dcc_top (
      .clk_i            (clk_i),
      .rst_i            (rst_i),
      .wb_cyc_i         (wb_cyc_i),
      .wb_stb_i         (wb_stb_i),
      .wb_we_i          (wb_we_i),
      .wb_adr_i         (wb_adr_i),
      .wb_sel_i         (wb_sel_i),
      .wb_dat_i         (wb_dat_i),
      .wb_dat_o         (wb_dat_o),
      .wb_ack_o         (wb_ack_o),
      .level_o          (level_o),
      .analog_out_pin_o (analog_out_pin_o),
      .gpio_out_i       (gpio_out_i),
      .gpio_oe_i        (gpio_oe_i),
      .gpio_in_o        (gpio_in_o),
      .pad_in_i         (pad_in_i),
      .pad_out_o        (pad_out_o),
      .pad_oe_o         (pad_oe_o),
      .pad_ibuf_en_o    (pad_ibuf_en_o)
   );

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // Whole run needs about 150 cycles; this cuts a hang short
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         miscompares = miscompares + 1;
         finish_test();
      end
   end

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic finish_test();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR at %0t: expected %h got %h", $time, exp, got);
      end
   endtask

   // Classic single cycle; request held until ack is sampled high
   task automatic wb_xfer(input logic we, input logic [7:0] adr,
                          input logic [7:0] dat, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel_v;
      wb_dat_i <= {24'h0, dat};
      // Only the bench timeout ends a wait for ack
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      // Ack comes one edge after the request is taken
      check(32'h2, n);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
      wb_xfer(1'b1, adr, dat, q);
   endtask

   task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
      wb_xfer(1'b0, adr, 8'h00, q);
      check(exp, q);
   endtask

   // Load and pin overrides land within two edges of the ack
   task automatic settle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      sel_v      = 4'hf;
      rst_i      <= 1'b1;
      wb_cyc_i   <= 1'b0;
      wb_stb_i   <= 1'b0;
      wb_we_i    <= 1'b0;
      wb_adr_i   <= 8'h00;
      wb_sel_i   <= 4'h0;
      wb_dat_i   <= 32'h0;
      gpio_out_i <= 2'b11;
      gpio_oe_i  <= 2'b11;
      pad_in_i   <= 2'b11;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(dcc_pkg::OFF_CTRL, 32'h0);
      rchk(dcc_pkg::OFF_ACTIVE, 32'h0);
      check(32'h0, {17'h0, level_o});
      check(32'h0, {30'h0, analog_out_pin_o});
      check(32'h3, {30'h0, pad_ibuf_en_o});
      wr(dcc_pkg::OFF_CTRL, 8'ha5);
      rchk(dcc_pkg::OFF_CTRL, 32'ha5);
      rchk(dcc_pkg::OFF_STATUS, 32'h2);
      check(32'h1, {31'h0, level_o.on});
      for (int i = 0; i < 4; i++) begin
         wr(dcc_pkg::OFF_CTRL, {4'h8, i[1:0], i[1:0]});
         settle();
         check({30'h0, i[1:0]}, {30'h0, level_o.pos_src});
         check({30'h0, i[1:0]}, {30'h0, level_o.neg_src});
         rchk(dcc_pkg::OFF_STATUS,
              {29'h0, (i == 3) || (i == 2 && !NEG1), 2'b10});
      end
      // Right justified, held until the strobe
      wr(dcc_pkg::OFF_CTRL, 8'h80);
      wr(dcc_pkg::OFF_HIGH, 8'hff);
      wr(dcc_pkg::OFF_LOW, 8'h5a);
      rchk(dcc_pkg::OFF_HIGH, 32'h03);
      rchk(dcc_pkg::OFF_LOW, 32'h5a);
      check(32'h0, {22'h0, level_o.level});
      rchk(dcc_pkg::OFF_ACTIVE, 32'h0);
      wr(dcc_pkg::OFF_LOAD, 8'h01);
      settle();
      check(32'h35a, {22'h0, level_o.level});
      rchk(dcc_pkg::OFF_LOAD, 32'h0);
      rchk(dcc_pkg::OFF_STATUS, 32'h2);
      rchk(dcc_pkg::OFF_ACTIVE, 32'h35a);
      // Left justified
      wr(dcc_pkg::OFF_CTRL, 8'hc0);
      wr(dcc_pkg::OFF_HIGH, 8'ha5);
      wr(dcc_pkg::OFF_LOW, 8'hff);
      rchk(dcc_pkg::OFF_LOW, 32'hc0);
      rchk(dcc_pkg::OFF_HIGH, 32'ha5);
      check(32'h35a, {22'h0, level_o.level});
      wr(dcc_pkg::OFF_LOAD, 8'h00);
      settle();
      check(32'h35a, {22'h0, level_o.level});
      wr(dcc_pkg::OFF_LOAD, 8'h01);
      settle();
      check(32'h297, {22'h0, level_o.level});
      wr(dcc_pkg::OFF_CTRL, 8'h00);
      settle();
      check(32'h297, {22'h0, level_o.level});
      check(32'h0, {31'h0, level_o.on});
      // Every combination of the two pin enables
      for (int k = 0; k < 4; k++) begin
         wr(dcc_pkg::OFF_CTRL, {2'b00, k[0], k[1], 4'h0});
         settle();
         check({30'h0, k[1:0]}, {30'h0, analog_out_pin_o});
         check({30'h0, ~k[1:0]}, {30'h0, pad_oe_o});
         check({30'h0, ~k[1:0]}, {30'h0, pad_out_o});
         check({30'h0, ~k[1:0]}, {30'h0, pad_ibuf_en_o});
         check({30'h0, ~k[1:0]}, {30'h0, gpio_in_o});
      end
      // Unmapped place: write ignored, reads zero
      wr(8'h20, 8'hff);
      rchk(8'h20, 32'h0);
      // Byte lane zero off: write acked but ignored
      sel_v = 4'he;
      wr(dcc_pkg::OFF_CTRL, 8'hff);
      sel_v = 4'hf;
      rchk(dcc_pkg::OFF_CTRL, 32'h30);
      // Reset in mid-run with pins and code active
      wr(dcc_pkg::OFF_CTRL, 8'hf5);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(dcc_pkg::OFF_CTRL, 32'h0);
      check(32'h0, {17'h0, level_o});
      check(32'h0, {30'h0, analog_out_pin_o});
      check(32'h3, {30'h0, pad_ibuf_en_o});
      finish_test();
   end
endmodule
